// ==== rtl/timed_trigger_output_unit.sv ====
// Timed trigger output unit: time compare, waveform generator, pin routing
`timescale 1ns/1ps
module timed_trigger_output_unit #(
    parameter int TIME_W = 32,
    parameter int PIN_N = trigger_unit_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire trigger_unit_pkg::reg_req_t regReq,
    output logic [15:0] regRdata,
    // System time
    input wire logic [TIME_W-1:0] sysTime,
    // Outputs of other units, per pin, to be ORed in
    input wire logic [PIN_N-1:0] otherUnitPins,
    // Pins and interrupt
    output logic [PIN_N-1:0] gpioOut,
    output logic irq
);
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        WAIT_TIME = 2'b01,
        RUN = 2'b10,
        FINISHED = 2'b11
    } state_t;

    trigger_unit_pkg::cfg_a_t cfg_r;
    logic [15:0] pulseWidth_r;
    logic [31:0] period_r;
    logic [15:0] repeatCount_r;
    logic [15:0] shiftPattern_r;
    logic [TIME_W-1:0] target_r;
    logic [1:0] status_r;
    logic [1:0] irqMask_r;
    state_t state_r;
    logic wave_r;
    logic [31:0] phaseCnt_r;
    logic [15:0] cyclesDone_r;
    logic [3:0] bitIdx_r;
    logic [15:0] regRdata_r;

    logic armWrite;
    logic doneEvt;
    logic faultEvt;
    logic timeReached;
    logic targetPast;
    logic [1:0] events;

    // Clock cycles for a count in a given step size, never below one cycle
    function automatic logic [31:0] toCycles(input logic [31:0] cnt,
                                             input int stepPs);
        logic [63:0] ps;
        logic [63:0] cyc;
        ps = 64'(cnt) * 64'(stepPs);
        cyc = (ps + 64'(trigger_unit_pkg::CLK_PERIOD_PS - 1))
              / 64'(trigger_unit_pkg::CLK_PERIOD_PS);
        if (cyc == 64'h0) begin
            cyc = 64'h1;
        end
        toCycles = cyc[31:0];
    endfunction : toCycles

    // Idle level of each pattern before firing
    // Low-going patterns rest high, so the first active phase is an edge
    function automatic logic idleLevel(input trigger_unit_pkg::pattern_t p);
        unique case (p)
            trigger_unit_pkg::FALLING_STEP_PATTERN,
            trigger_unit_pkg::LOW_PULSE_PATTERN,
            trigger_unit_pkg::LOW_PERIODIC_PATTERN: idleLevel = 1'b1;
            default: idleLevel = 1'b0;
        endcase
    endfunction : idleLevel

    // Durations in clock cycles; with a 100 ns clock the 8 ns and 1 ns
    // steps are rounded up, so very short settings stretch to one cycle
    logic [31:0] pulseCycles;
    logic [31:0] periodCycles;
    logic [31:0] lowCycles;
    assign pulseCycles = toCycles({16'h0000, pulseWidth_r},
                                  trigger_unit_pkg::PULSE_STEP_PS);
    assign periodCycles = toCycles(period_r, trigger_unit_pkg::PERIOD_STEP_PS);
    assign lowCycles = (periodCycles > pulseCycles) ?
                       (periodCycles - pulseCycles) : 32'h1;

    assign armWrite = regReq.wr && (regReq.addr == trigger_unit_pkg::CONTROL_OFS)
                      && regReq.wdata[trigger_unit_pkg::ARM_BIT];

    // Time compare; the system time only steps forward, so a target that
    // is already behind at arming can never be met without the immediate bit
    assign timeReached = (sysTime >= target_r);
    assign targetPast = (sysTime > target_r);

    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_r <= trigger_unit_pkg::CFG_A_RESET[9:0];
            pulseWidth_r <= 16'h0000;
            period_r <= 32'h0000_0000;
            repeatCount_r <= 16'h0000;
            shiftPattern_r <= 16'h0000;
            target_r <= '0;
            irqMask_r <= 2'h0;
        end else if (regReq.wr) begin
            unique case (regReq.addr)
                trigger_unit_pkg::CFG_A_OFS:
                    cfg_r <= regReq.wdata[9:0]
                             & trigger_unit_pkg::CFG_A_RW_MASK[9:0];
                trigger_unit_pkg::PULSE_WIDTH_OFS: pulseWidth_r <= regReq.wdata;
                trigger_unit_pkg::PERIOD_LO_OFS: period_r[15:0] <= regReq.wdata;
                trigger_unit_pkg::PERIOD_HI_OFS: period_r[31:16] <= regReq.wdata;
                trigger_unit_pkg::REPEAT_COUNT_OFS:
                    repeatCount_r <= regReq.wdata;
                trigger_unit_pkg::SHIFT_PATTERN_OFS:
                    shiftPattern_r <= regReq.wdata;
                trigger_unit_pkg::TARGET_LO_OFS:
                    target_r[15:0] <= regReq.wdata;
                trigger_unit_pkg::TARGET_HI_OFS:
                    target_r[TIME_W-1:16] <= regReq.wdata[TIME_W-17:0];
                trigger_unit_pkg::IRQ_MASK_OFS: irqMask_r <= regReq.wdata[1:0];
                default: ;
            endcase
        end
    end

    // Sequencer and waveform generator
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= IDLE;
            wave_r <= 1'b0;
            phaseCnt_r <= 32'h0;
            cyclesDone_r <= 16'h0;
            bitIdx_r <= 4'h0;
        end else if (armWrite) begin
            // passed target without immediate never fires
            // It is reported as a fault instead of firing late
            if (!cfg_r.immediate && targetPast) begin
                state_r <= FINISHED;
            end else begin
                state_r <= WAIT_TIME;
            end
            wave_r <= idleLevel(cfg_r.pattern);
            phaseCnt_r <= 32'h0;
            cyclesDone_r <= 16'h0;
            bitIdx_r <= 4'h0;
        end else begin
            unique case (state_r)
                IDLE: wave_r <= idleLevel(cfg_r.pattern);
                WAIT_TIME: begin
                    if ((cfg_r.immediate && targetPast) || timeReached) begin
                        state_r <= RUN;
                        phaseCnt_r <= 32'h1;
                        unique case (cfg_r.pattern)
                            trigger_unit_pkg::FALLING_STEP_PATTERN: begin
                                wave_r <= 1'b0;
                                state_r <= FINISHED;
                            end
                            trigger_unit_pkg::RISING_STEP_PATTERN: begin
                                wave_r <= 1'b1;
                                state_r <= FINISHED;
                            end
                            trigger_unit_pkg::LOW_PULSE_PATTERN,
                            trigger_unit_pkg::LOW_PERIODIC_PATTERN:
                                wave_r <= 1'b0;
                            trigger_unit_pkg::HIGH_PULSE_PATTERN,
                            trigger_unit_pkg::HIGH_PERIODIC_PATTERN:
                                wave_r <= 1'b1;
                            trigger_unit_pkg::BIT_SHIFT_PATTERN: begin
                                wave_r <= shiftPattern_r[0];
                                bitIdx_r <= 4'h1;
                                cyclesDone_r <= 16'h1;
                            end
                            trigger_unit_pkg::RESERVED_PATTERN:
                                state_r <= FINISHED;
                        endcase
                    end
                end
                RUN: begin
                    phaseCnt_r <= phaseCnt_r + 32'h1;
                    unique case (cfg_r.pattern)
                        trigger_unit_pkg::LOW_PULSE_PATTERN,
                        trigger_unit_pkg::HIGH_PULSE_PATTERN: begin
                            if (phaseCnt_r >= pulseCycles) begin
                                wave_r <= ~wave_r;
                                state_r <= FINISHED;
                            end
                        end
                        trigger_unit_pkg::LOW_PERIODIC_PATTERN,
                        trigger_unit_pkg::HIGH_PERIODIC_PATTERN: begin
                            if (wave_r == cfg_r.pattern[0]) begin
                                if (phaseCnt_r >= pulseCycles) begin
                                    wave_r <= ~wave_r;
                                    phaseCnt_r <= 32'h1;
                                end
                            end else if (phaseCnt_r >= lowCycles) begin
                                phaseCnt_r <= 32'h1;
                                cyclesDone_r <= cyclesDone_r + 16'h1;
                                if (repeatCount_r != 16'h0 &&
                                    cyclesDone_r + 16'h1 >= repeatCount_r) begin
                                    state_r <= FINISHED;
                                end else begin
                                    wave_r <= ~wave_r;
                                end
                            end
                        end
                        trigger_unit_pkg::BIT_SHIFT_PATTERN: begin
                            if (phaseCnt_r >= periodCycles) begin
                                phaseCnt_r <= 32'h1;
                                if (repeatCount_r != 16'h0 &&
                                    cyclesDone_r >= repeatCount_r) begin
                                    state_r <= FINISHED;
                                end else begin
                                    wave_r <= shiftPattern_r[bitIdx_r];
                                    bitIdx_r <= bitIdx_r + 4'h1;
                                    cyclesDone_r <= cyclesDone_r + 16'h1;
                                end
                            end
                        end
                        default: state_r <= FINISHED;
                    endcase
                end
                FINISHED: ;
            endcase
        end
    end

    // Completion when a step or single pulse ends; fault when armed with an unusable setup
    assign doneEvt = (state_r == RUN || state_r == WAIT_TIME) &&
                     !armWrite && (
                     (state_r == WAIT_TIME && cfg_r.pattern inside {
                         trigger_unit_pkg::FALLING_STEP_PATTERN,
                         trigger_unit_pkg::RISING_STEP_PATTERN} &&
                      ((cfg_r.immediate && targetPast) || timeReached)) ||
                     (state_r == RUN && cfg_r.pattern inside {
                         trigger_unit_pkg::LOW_PULSE_PATTERN,
                         trigger_unit_pkg::HIGH_PULSE_PATTERN} &&
                      phaseCnt_r >= pulseCycles));
    // Target already gone without immediate, bad pin or reserved pattern
    assign faultEvt = armWrite && ((!cfg_r.immediate && targetPast) ||
                      cfg_r.pin > trigger_unit_pkg::PIN_MAX ||
                      cfg_r.pattern == trigger_unit_pkg::RESERVED_PATTERN);

    assign events = cfg_r.notify ? {faultEvt, doneEvt} : 2'b00;

    // Sticky status; a new event wins over a write-one clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_r <= 2'h0;
        end else begin
            if (regReq.wr && regReq.addr == trigger_unit_pkg::STATUS_OFS) begin
                status_r <= (status_r & ~regReq.wdata[1:0]) | events;
            end else begin
                status_r <= status_r | events;
            end
        end
    end

    assign irq = |(status_r & irqMask_r);

    // Read data one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdata_r <= 16'h0000;
        end else if (regReq.rd) begin
            unique case (regReq.addr)
                trigger_unit_pkg::CFG_A_OFS: regRdata_r <= {6'h00, cfg_r};
                trigger_unit_pkg::PULSE_WIDTH_OFS: regRdata_r <= pulseWidth_r;
                trigger_unit_pkg::PERIOD_LO_OFS: regRdata_r <= period_r[15:0];
                trigger_unit_pkg::PERIOD_HI_OFS: regRdata_r <= period_r[31:16];
                trigger_unit_pkg::REPEAT_COUNT_OFS: regRdata_r <= repeatCount_r;
                trigger_unit_pkg::SHIFT_PATTERN_OFS:
                    regRdata_r <= shiftPattern_r;
                trigger_unit_pkg::TARGET_LO_OFS: regRdata_r <= target_r[15:0];
                trigger_unit_pkg::TARGET_HI_OFS:
                    regRdata_r <= 16'(target_r[TIME_W-1:16]);
                trigger_unit_pkg::STATUS_OFS: regRdata_r <= {14'h0, status_r};
                trigger_unit_pkg::IRQ_MASK_OFS: regRdata_r <= {14'h0, irqMask_r};
                trigger_unit_pkg::CONTROL_OFS:
                    regRdata_r <= {14'h0, state_r};
                default: regRdata_r <= 16'h0000;
            endcase
        end else begin
            regRdata_r <= 16'h0000;
        end
    end
    assign regRdata = regRdata_r;

    // Pin routing; unused pin codes drive nothing from this unit
    // Registered so the pins never glitch while the pin field changes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gpioOut <= '0;
        end else begin
            for (int i = 0; i < PIN_N; i++) begin
                gpioOut[i] <= otherUnitPins[i] |
                              (wave_r && (cfg_r.pin == 4'(i)));
            end
        end
    end
endmodule : timed_trigger_output_unit

// ==== rtl/trigger_unit_pkg.sv ====
// Package: register map, field layout, timing constants and types
package trigger_unit_pkg;
    // Register byte offsets (16-bit registers on a 16-bit plain port)
    localparam logic [11:0] CFG_A_OFS = 12'h228;
    localparam logic [11:0] PULSE_WIDTH_OFS = 12'h22a;
    localparam logic [11:0] PERIOD_LO_OFS = 12'h22c;
    localparam logic [11:0] PERIOD_HI_OFS = 12'h22e;
    localparam logic [11:0] REPEAT_COUNT_OFS = 12'h230;
    localparam logic [11:0] SHIFT_PATTERN_OFS = 12'h232;
    localparam logic [11:0] TARGET_LO_OFS = 12'h240;
    localparam logic [11:0] TARGET_HI_OFS = 12'h242;
    localparam logic [11:0] STATUS_OFS = 12'h244;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h246;
    localparam logic [11:0] CONTROL_OFS = 12'h248;

    // Field positions in the first configuration register
    localparam int IMMEDIATE_BIT = 9;
    localparam int NOTIFY_BIT = 8;
    localparam int PATTERN_LSB = 4;
    localparam int PIN_LSB = 0;
    localparam logic [15:0] CFG_A_RW_MASK = 16'h037f;
    localparam logic [15:0] CFG_A_RESET = 16'h0000;

    // Status and control bit positions
    localparam int DONE_BIT = 0;
    localparam int FAULT_BIT = 1;
    localparam int ARM_BIT = 0;

    localparam int PIN_COUNT = 12;
    localparam logic [3:0] PIN_MAX = 4'hb;

    // Time steps in picoseconds and clock period
    localparam int CLK_PERIOD_PS = 100000;
    localparam int PULSE_STEP_PS = 8000;
    localparam int PERIOD_STEP_PS = 1000;

    typedef enum logic [2:0] {
        FALLING_STEP_PATTERN = 3'b000,
        RISING_STEP_PATTERN = 3'b001,
        LOW_PULSE_PATTERN = 3'b010,
        HIGH_PULSE_PATTERN = 3'b011,
        LOW_PERIODIC_PATTERN = 3'b100,
        HIGH_PERIODIC_PATTERN = 3'b101,
        BIT_SHIFT_PATTERN = 3'b110,
        RESERVED_PATTERN = 3'b111
    } pattern_t;

    typedef struct packed {
        logic immediate;
        logic notify;
        // Bit 7 is read-only and always reads zero
        logic spare;
        pattern_t pattern;
        logic [3:0] pin;
    } cfg_a_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : trigger_unit_pkg

// ==== sim/timed_trigger_output_unit_sva.sv ====
// Checker: register port, interrupt and pin routing properties
`timescale 1ns/1ps
module timed_trigger_output_unit_sva #(
    parameter int TIME_W = 32,
    parameter int PIN_N = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire trigger_unit_pkg::reg_req_t regReq,
    input wire logic [15:0] regRdata,
    // Time, pins and interrupt
    input wire logic [TIME_W-1:0] sysTime,
    input wire logic [PIN_N-1:0] otherUnitPins,
    input wire logic [PIN_N-1:0] gpioOut,
    input wire logic irq
);
    logic [15:0] cfgR;
    logic [PIN_N-1:0] othersQ;
    logic [PIN_N-1:0] own;
    logic cfgWr;
    logic cfgRd;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    assign cfgWr = regReq.wr && regReq.addr == trigger_unit_pkg::CFG_A_OFS;
    assign cfgRd = regReq.rd && regReq.addr == trigger_unit_pkg::CFG_A_OFS;
    // Shadow of the config register, to know pin and pattern
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfgR <= 16'h0000;
        end else if (cfgWr) begin
            cfgR <= regReq.wdata;
        end
    end
    // Pins leave one cycle after the other units' levels
    always_ff @(posedge clk_sys) begin
        othersQ <= otherUnitPins;
    end
    assign own = gpioOut & ~othersQ;
    sequence s_cfg_wr; cfgWr; endsequence
    sequence s_cfg_rd; cfgRd; endsequence
    sequence s_res4; (cfgR[6:4] == 3'b111) [*4]; endsequence
    property p_cfg_rw;
        s_cfg_wr ##1 s_cfg_rd |=> regRdata ==
            ($past(regReq.wdata, 2) & trigger_unit_pkg::CFG_A_RW_MASK);
    endproperty
    a_cfg_rw: assert property (p_cfg_rw) else $error("config readback");
    property p_stat_rd;
        regReq.rd && regReq.addr == trigger_unit_pkg::STATUS_OFS
            |=> regRdata[15:2] == 14'h0000;
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status bits");
    property p_ctl_rd;
        regReq.rd && regReq.addr == trigger_unit_pkg::CONTROL_OFS
            |=> regRdata[15:2] == 14'h0000;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("state code");
    property p_mask_off;
        regReq.wr && regReq.addr == trigger_unit_pkg::IRQ_MASK_OFS &&
            regReq.wdata[1:0] == 2'b00 |=> !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq masked");
    property p_or;
        !$past(srst) |-> (gpioOut & othersQ) == othersQ;
    endproperty
    a_or: assert property (p_or) else $error("pin OR lost");
    property p_onehot;
        !$past(srst) |-> $onehot0(own);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two pins");
    property p_bad_pin;
        !$past(srst) && cfgR[3:0] > 4'hb && $past(cfgR[3:0]) > 4'hb
            |-> gpioOut == othersQ;
    endproperty
    a_bad_pin: assert property (p_bad_pin) else $error("unused pin");
    property p_reserved;
        s_res4 |-> own == $past(own);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved");
endmodule : timed_trigger_output_unit_sva

bind timed_trigger_output_unit timed_trigger_output_unit_sva #(
    .TIME_W(TIME_W), .PIN_N(PIN_N)
) i_sva (
    .clk_sys(clk_sys), .srst(srst), .regReq(regReq), .regRdata(regRdata),
    .sysTime(sysTime), .otherUnitPins(otherUnitPins), .gpioOut(gpioOut),
    .irq(irq)
);

// ==== sim/trigger_pin_model.sv ====
// Far side: other units on the shared pins and a level meter on one pin
`timescale 1ns/1ps
module trigger_pin_model #(
    parameter int PIN_N = 12
) (
    // Clock
    input wire logic clk_sys,
    // Pins
    input wire logic [PIN_N-1:0] gpioOut,
    output logic [PIN_N-1:0] otherUnitPins,
    // Meter control
    input wire logic [3:0] pinSel,
    input wire logic clear,
    // Meter results
    output logic [15:0] hiCnt,
    output logic [15:0] riseCnt,
    output logic [15:0] fallCnt
);
    logic lvl;
    logic lastLvl = 1'b0;
    assign lvl = gpioOut[pinSel];
    initial otherUnitPins = '0;
    always @(posedge clk_sys) begin
        otherUnitPins <= PIN_N'($urandom) & ~(PIN_N'(1) << pinSel);
    end
    always @(posedge clk_sys) begin
        lastLvl <= lvl;
        if (clear) begin
            hiCnt <= 16'h0000;
            riseCnt <= 16'h0000;
            fallCnt <= 16'h0000;
        end else begin
            hiCnt <= hiCnt + {15'h0, lvl};
            riseCnt <= riseCnt + {15'h0, lvl & ~lastLvl};
            fallCnt <= fallCnt + {15'h0, ~lvl & lastLvl};
        end
    end
endmodule : trigger_pin_model

// ==== sim/timed_trigger_output_unit_tb.sv ====
// Self-checking bench for the timed trigger output unit
`timescale 1ns/1ps
module timed_trigger_output_unit_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    trigger_unit_pkg::reg_req_t regReq = '0;
    logic [15:0] regRdata;
    logic [31:0] sysTime = 32'h0;
    logic [11:0] otherUnitPins;
    logic [11:0] gpioOut;
    logic irq;
    logic clear = 1'b0;
    logic [3:0] pinSel = 4'h0;
    logic [15:0] hiCnt;
    logic [15:0] riseCnt;
    logic [15:0] fallCnt;
    logic rdSeen = 1'b0;
    logic [15:0] expQ[$];
    string nameQ[$];
    int failures = 0;
    int compares = 0;
    logic [15:0] pat = 16'h0;
    logic [15:0] expR[6] = '{16'h0, 16'h1, 16'h1, 16'h1, 16'h3, 16'h3};
    logic [15:0] expF[6] = '{16'h1, 16'h0, 16'h1, 16'h1, 16'h3, 16'h3};
    logic [15:0] expH[6] = '{16'hffff, 16'hffff, 16'hffff, 16'h2,
                             16'hffff, 16'h6};
    logic expL[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] cntT[3] = '{16'h10, 16'h8, 16'h0};
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) sysTime <= sysTime + 32'd100;
    timed_trigger_output_unit i_dut (.clk_sys(clk_sys), .srst(srst),
        .regReq(regReq), .regRdata(regRdata), .sysTime(sysTime),
        .otherUnitPins(otherUnitPins), .gpioOut(gpioOut), .irq(irq));
    trigger_pin_model i_pin (.clk_sys(clk_sys), .gpioOut(gpioOut),
        .otherUnitPins(otherUnitPins), .pinSel(pinSel), .clear(clear),
        .hiCnt(hiCnt), .riseCnt(riseCnt), .fallCnt(fallCnt));
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic op(input logic [11:0] a, input logic [15:0] d,
                      input logic w, input logic [15:0] e, input string n);
        @(posedge clk_sys);
        regReq <= '{a, d, w, ~w};
        if (!w) begin
            expQ.push_back(e);
            nameQ.push_back(n);
        end
    endtask : op
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        op(a, d, 1'b1, 16'h0, "");
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] e,
                      input string n);
        op(a, 16'h0, 1'b0, e, n);
    endtask : rd
    task automatic idl();
        @(posedge clk_sys);
        regReq.wr <= 1'b0;
        regReq.rd <= 1'b0;
        #1;
    endtask : idl
    // Reads answer in the next cycle only
    always @(posedge clk_sys) begin
        rdSeen <= regReq.rd;
        if (rdSeen) chk(nameQ.pop_front(), expQ.pop_front(), regRdata);
    end
    task automatic measure(input int n);
        @(posedge clk_sys);
        regReq.wr <= 1'b0;
        regReq.rd <= 1'b0;
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : measure
    function automatic logic [15:0] cfgw(input logic im, input logic nt,
                                         input logic [2:0] p, input logic [3:0] q);
        return {6'h00, im, nt, 1'b0, p, q};
    endfunction : cfgw
    // Reset, program every register except status, then arm
    task automatic setup(input logic [15:0] c, input logic [31:0] t,
                         input logic [15:0] per, input logic [15:0] cnt);
        @(posedge clk_sys);
        srst <= 1'b1;
        regReq.wr <= 1'b0;
        regReq.rd <= 1'b0;
        pinSel <= c[3:0];
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        wr(trigger_unit_pkg::PULSE_WIDTH_OFS, 16'd13);
        wr(trigger_unit_pkg::PERIOD_LO_OFS, per);
        wr(trigger_unit_pkg::PERIOD_HI_OFS, 16'h0000);
        wr(trigger_unit_pkg::REPEAT_COUNT_OFS, cnt);
        wr(trigger_unit_pkg::SHIFT_PATTERN_OFS, pat);
        wr(trigger_unit_pkg::TARGET_LO_OFS, t[15:0]);
        wr(trigger_unit_pkg::TARGET_HI_OFS, t[31:16]);
        wr(trigger_unit_pkg::IRQ_MASK_OFS, 16'h0003);
        wr(trigger_unit_pkg::CFG_A_OFS, c);
        rd(trigger_unit_pkg::CFG_A_OFS, c, "config");
        wr(trigger_unit_pkg::CONTROL_OFS, 16'h0001);
    endtask : setup
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Watchdog, far beyond the well under one thousand cycles of the run
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h5a9f));
        sysTime = {16'h0, 16'($urandom)};
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rd(12'h234, 16'h0000, "unmapped");
        rd(trigger_unit_pkg::STATUS_OFS, 16'h0000, "status reset");
        wr(trigger_unit_pkg::CFG_A_OFS, 16'hffff);
        rd(trigger_unit_pkg::CFG_A_OFS, 16'h037f, "config mask");
        for (int i = 0; i < 6; i++) begin
            setup(cfgw(1'b1, 1'b1, 3'(i), 4'($urandom_range(11))), 32'h0,
                  16'h01f4, 16'h0003);
            measure(30);
            chk("rises", expR[i], riseCnt);
            chk("falls", expF[i], fallCnt);
            if (expH[i] != 16'hffff) chk("active", expH[i], hiCnt);
            chk("level", {15'h0, expL[i]}, {15'h0, gpioOut[pinSel]});
            rd(trigger_unit_pkg::STATUS_OFS, {15'h0, i < 4}, "done");
            idl();
            chk("irq", {15'h0, i < 4}, {15'h0, irq});
            wr(trigger_unit_pkg::IRQ_MASK_OFS, 16'h0000);
            wr(trigger_unit_pkg::STATUS_OFS, 16'h0003);
            rd(trigger_unit_pkg::STATUS_OFS, 16'h0000, "cleared");
            idl();
            chk("irq masked", 16'h0000, {15'h0, irq});
        end
        // Trailing pattern bits kept low so the line ends idle
        for (int k = 0; k < 3; k++) begin
            pat = 16'($urandom) & 16'h7f7f;
            setup(cfgw(1'b1, 1'b0, 3'b110, 4'($urandom_range(11))), 32'h0,
                  16'h0064, cntT[k]);
            measure(48);
            if (cntT[k] == 16'h0) begin
                chk("endless", 16'h1,
                    {15'h0, hiCnt >= 16'(2 * $countones(pat))});
            end else begin
                chk("ones", 16'($countones(pat & ~(16'hffff << cntT[k]))),
                    hiCnt);
            end
        end
        setup(cfgw(1'b0, 1'b1, 3'b001, 4'h5), sysTime + 32'd2900, 16'h1f4,
              16'h0);
        measure(8);
        chk("early", 16'h0, riseCnt);
        measure(14);
        chk("on time", 16'h1, riseCnt);
        setup(cfgw(1'b0, 1'b1, 3'b001, 4'h5), 32'h0, 16'h1f4, 16'h0);
        measure(10);
        chk("passed", 16'h0, riseCnt);
        rd(trigger_unit_pkg::STATUS_OFS, 16'h0002, "late fault");
        setup(cfgw(1'b1, 1'b0, 3'b111, 4'h3), 32'h0, 16'h1f4, 16'h0);
        measure(10);
        chk("reserved", 16'h0, riseCnt);
        rd(trigger_unit_pkg::STATUS_OFS, 16'h0000, "hidden");
        setup(cfgw(1'b1, 1'b1, 3'b111, 4'h3), 32'h0, 16'h1f4, 16'h0);
        measure(4);
        rd(trigger_unit_pkg::STATUS_OFS, 16'h0002, "fault");
        setup(cfgw(1'b1, 1'b0, 3'b001, 4'hc), 32'h0, 16'h1f4, 16'h0);
        measure(10);
        idl();
        finish_test();
    end
endmodule : timed_trigger_output_unit_tb
